// ---- src/motion_cmd.sv ----
// Motion command interpreter: halt, acceleration, parameter persistence
`timescale 1ns/1ns
module motion_cmd
  #(parameter int AXES = motion_cmd_pkg::AXES)
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic power_on_i,
  input wire logic reset_button_i,
  input wire logic factory_restore_jumper_i,
  input wire logic [AXES-1:0] axis_moving_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [AXES-1:0] motion_stop_o,
  output logic program_stop_o,
  output logic [AXES-1:0] amp_enable_o,
  output logic accel_update_o
  );
  // ----------------------------------------
  // State
  // ----------------------------------------
  motion_cmd_pkg::axis_par_s par [AXES];
  motion_cmd_pkg::axis_par_s nv [AXES];
  logic nv_valid;
  logic [2:0] axis_sel;
  logic [AXES-1:0] ooe;
  logic [31:0] reply;
  logic [3:0] digits;
  motion_cmd_pkg::op_e op_state;
  logic [1:0] mr_seq;
  logic operand_ok;
  logic [2:0] operand_axis;
  logic last_halt_prog;
  logic wr;
  logic rd;
  logic [7:0] adr;
  logic [3:0] cmd;
  logic ordinary_rst;
  logic master_rst;
  logic [7:0] ch;
  logic [motion_cmd_pkg::ACC_W-1:0] acc_q;
  assign adr = wb_adr_i[7:0];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign cmd = wb_dat_i[3:0];
  assign ch = wb_dat_i[7:0];

  // Truncate downward to the 1024 quantum, clamp to legal range
  function automatic logic [motion_cmd_pkg::ACC_W-1:0] quantise(input logic [31:0] v);
    logic [31:0] t;
    t = {v[31:motion_cmd_pkg::ACC_LSB], {motion_cmd_pkg::ACC_LSB{1'b0}}}; // [R6]
    if (t < 32'(motion_cmd_pkg::ACC_MIN))
      t = 32'(motion_cmd_pkg::ACC_MIN);
    else if (t > 32'(motion_cmd_pkg::ACC_MAX))
      t = 32'(motion_cmd_pkg::ACC_MAX);
    return t[motion_cmd_pkg::ACC_W-1:0];
  endfunction
  assign acc_q = quantise(wb_dat_i);

  // Factory-restore character sequence on the char register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mr_seq <= 2'd0;
    else if (ce_i && wr && adr == motion_cmd_pkg::CHAR_OFF)
    begin
      if (ch == motion_cmd_pkg::CH_CTRL_R)
        mr_seq <= 2'd1;
      else if (ch == motion_cmd_pkg::CH_CTRL_S && mr_seq == 2'd1)
        mr_seq <= 2'd2;
      else
        mr_seq <= 2'd0;
    end
  end

  // Reset sources [R14] [R16]
  assign master_rst = ce_i && ((wr && adr == motion_cmd_pkg::CHAR_OFF &&
    ch == motion_cmd_pkg::CH_RET && mr_seq == 2'd2) ||
    (wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::FACTORY_CODE) ||
    ((power_on_i || reset_button_i) && factory_restore_jumper_i)); // [R16]
  assign ordinary_rst = ce_i && !master_rst && (power_on_i || reset_button_i ||
    (wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::RESTART_CODE)); // [R14]

  // Operand name recogniser: underscore, A, C, axis letter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_state <= motion_cmd_pkg::OP_IDLE;
      operand_ok <= 1'b0;
      operand_axis <= 3'd0;
    end
    else if (ce_i && wr && adr == motion_cmd_pkg::OPERAND_OFF)
    begin
      operand_ok <= 1'b0;
      unique case (op_state)
        motion_cmd_pkg::OP_IDLE:
          op_state <= (ch == motion_cmd_pkg::CH_US) ? motion_cmd_pkg::OP_US
                                                    : motion_cmd_pkg::OP_IDLE; // [R11]
        motion_cmd_pkg::OP_US:
          op_state <= (ch == motion_cmd_pkg::CH_A) ? motion_cmd_pkg::OP_A
                                                   : motion_cmd_pkg::OP_IDLE;
        motion_cmd_pkg::OP_A:
          op_state <= (ch == motion_cmd_pkg::CH_C) ? motion_cmd_pkg::OP_C
                                                   : motion_cmd_pkg::OP_IDLE;
        motion_cmd_pkg::OP_C:
        begin
          op_state <= motion_cmd_pkg::OP_IDLE;
          if (ch >= motion_cmd_pkg::CH_A && ch < motion_cmd_pkg::CH_A + 8'(AXES))
          begin
            operand_ok <= 1'b1; // [R11]
            operand_axis <= 3'(ch - motion_cmd_pkg::CH_A);
          end
          else if (ch >= motion_cmd_pkg::CH_X && ch < motion_cmd_pkg::CH_X + 8'd2)
          begin
            operand_ok <= 1'b1;
            operand_axis <= 3'(ch - motion_cmd_pkg::CH_X);
          end
        end
      endcase
    end
  end

  // Axis select, off-on-error enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      axis_sel <= 3'd0;
      ooe <= '0;
    end
    else if (ce_i && wr && adr == motion_cmd_pkg::AXIS_SEL_OFF)
      axis_sel <= wb_dat_i[2:0];
    else if (ce_i && wr && adr == motion_cmd_pkg::OOE_OFF)
      ooe <= wb_dat_i[AXES-1:0];
  end

  // Per-axis live parameters and non-volatile copy
  generate
    for (genvar i = 0; i < AXES; i++)
    begin : g_axis
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          par[i].acc <= motion_cmd_pkg::ACC_DEF;
          par[i].gain <= motion_cmd_pkg::GAIN_DEF; // [R18]
          nv[i].acc <= motion_cmd_pkg::ACC_DEF;
          nv[i].gain <= motion_cmd_pkg::GAIN_DEF;
        end
        else if (ce_i)
        begin
          if (master_rst)
          begin
            par[i].acc <= motion_cmd_pkg::ACC_DEF; // [R15]
            par[i].gain <= motion_cmd_pkg::GAIN_DEF;
            nv[i].acc <= motion_cmd_pkg::ACC_DEF;
            nv[i].gain <= motion_cmd_pkg::GAIN_DEF;
          end
          else if (ordinary_rst)
            par[i] <= nv_valid ? nv[i] : motion_cmd_pkg::axis_par_s'({motion_cmd_pkg::ACC_DEF,
              motion_cmd_pkg::GAIN_DEF}); // [R13] [R17] [R18]
          else if (wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::SAVE_CODE)
            nv[i] <= par[i]; // [R12]
          else if (wr && axis_sel == 3'(i) && adr == motion_cmd_pkg::ACC_OFF)
            par[i].acc <= acc_q; // [R5] [R6] [R8]
          else if (wr && axis_sel == 3'(i) && adr == motion_cmd_pkg::GAIN_OFF)
            par[i].gain <= wb_dat_i[motion_cmd_pkg::GAIN_W-1:0];
        end
      end
    end
  endgenerate

  // Saved-image flag survives ordinary reset, cleared by master reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nv_valid <= 1'b0;
    else if (ce_i && master_rst)
      nv_valid <= 1'b0; // [R15] [R17]
    else if (ce_i && wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::SAVE_CODE)
      nv_valid <= 1'b1; // [R12]
  end

  // Halt, servo enable and motion outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      motion_stop_o <= '0;
      program_stop_o <= 1'b0;
      amp_enable_o <= '1;
      last_halt_prog <= 1'b0;
    end
    else if (ce_i)
    begin
      motion_stop_o <= '0;
      program_stop_o <= 1'b0;
      if (master_rst || ordinary_rst)
        amp_enable_o <= '1;
      else if (wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::HALT_CODE)
      begin
        motion_stop_o <= axis_moving_i; // [R1] [R4]
        program_stop_o <= !wb_dat_i[4]; // [R2]
        last_halt_prog <= !wb_dat_i[4];
        amp_enable_o <= amp_enable_o & ~ooe; // [R3]
      end
      else if (wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::SERVO_CODE)
        amp_enable_o <= '1; // [R3]
    end
  end

  // Acceleration change notice to the profiler, also during motion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      accel_update_o <= 1'b0;
    else if (ce_i)
      accel_update_o <= wr && adr == motion_cmd_pkg::ACC_OFF; // [R8]
  end

  // Interrogation reply: stored value, digit count of the format
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reply <= '0;
      digits <= 4'd0;
    end
    else if (ce_i && wr && adr == motion_cmd_pkg::REPLY_OFF)
    begin
      reply <= 32'(par[axis_sel].acc); // [R9]
      digits <= 4'(motion_cmd_pkg::DIGIT_CYC); // [R19]
    end
  end

  // Wishbone classic slave: registered ack one cycle after the request, ack for every address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= '0;
      if (rd)
      begin
        unique case (adr)
          motion_cmd_pkg::STATUS_OFF:
            wb_dat_o <= {20'h00000, 1'b0, last_halt_prog, nv_valid, operand_ok,
              amp_enable_o};
          motion_cmd_pkg::AXIS_SEL_OFF: wb_dat_o <= {29'h0, axis_sel};
          motion_cmd_pkg::ACC_OFF: wb_dat_o <= 32'(par[axis_sel].acc);
          motion_cmd_pkg::GAIN_OFF: wb_dat_o <= 32'(par[axis_sel].gain);
          motion_cmd_pkg::OOE_OFF: wb_dat_o <= 32'(ooe);
          motion_cmd_pkg::OPERAND_OFF:
            wb_dat_o <= operand_ok ? 32'(par[operand_axis].acc) : 32'h0; // [R10]
          motion_cmd_pkg::REPLY_OFF: wb_dat_o <= {digits, reply[27:0]}; // [R9] [R19]
          motion_cmd_pkg::MOVE_OFF: wb_dat_o <= 32'(axis_moving_i);
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence halt_req_s;
    wr && ce_i && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::HALT_CODE &&
      !master_rst && !ordinary_rst;
  endsequence
  halt_stops_all_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    halt_req_s |=> motion_stop_o == $past(axis_moving_i))
    else $error("halt did not stop moving axes");
  halt_program_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    halt_req_s |=> program_stop_o == !$past(wb_dat_i[4]))
    else $error("program stop wrong after halt");
  halt_amp_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    halt_req_s |=> (amp_enable_o & $past(ooe)) == '0)
    else $error("amplifier left on after halt");
  accel_quant_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    wr && ce_i && adr == motion_cmd_pkg::ACC_OFF && !master_rst && !ordinary_rst
    |=> par[$past(axis_sel)].acc[motion_cmd_pkg::ACC_LSB-1:0] == '0)
    else $error("acceleration not quantised");
  accel_range_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    par[axis_sel].acc >= motion_cmd_pkg::ACC_MIN && par[axis_sel].acc <= motion_cmd_pkg::ACC_MAX)
    else $error("acceleration out of range");
  save_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    ce_i && !master_rst && wr && adr == motion_cmd_pkg::CMD_OFF && cmd == motion_cmd_pkg::SAVE_CODE
    |=> nv_valid)
    else $error("save did not mark image");
  master_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    master_rst |=> !nv_valid && par[0].gain == motion_cmd_pkg::GAIN_DEF)
    else $error("master reset did not restore defaults");
  restore_saved_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    ordinary_rst && nv_valid |=> par[0] == $past(nv[0]))
    else $error("saved value not restored");
  reply_digits_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    ce_i && wr && adr == motion_cmd_pkg::REPLY_OFF |=> digits == 4'd8)
    else $error("reply format wrong");
endmodule

// ---- pkg/motion_cmd_pkg.sv ----
// Constants, register map and carrier types of the motion command block
// Operation
// [R1] Halt stops all commanded motion at once, no deceleration ramp.
// [R2] Halt argument 0 or none also stops the program; argument 1 motion only.
// [R3] Halt disables amplifier of axes with off-on-error set; servo enable re-enables.
// [R4] Halt acts on every moving axis together; no single-axis halt.
// [R5] Accel command sets per-axis acceleration for position and jog moves.
// [R6] Written acceleration is truncated down to a multiple of 1024.
// [R7] Host supplies acceleration between 1024 and 67107840.
// [R8] New acceleration is accepted during motion and used at once.
// [R9] Interrogation returns the stored quantised acceleration of an axis.
// [R10] Stored acceleration is readable as an operand by programs.
// [R11] Operands are recognised by leading underscore, command name, axis letter.
// [R12] Save command copies setup parameters into non-volatile storage.
// [R13] Ordinary reset loads saved values if present, else factory defaults.
// [R14] Power cycle, reset button and restart command give ordinary reset.
// [R15] Master reset restores defaults and erases non-volatile storage.
// [R16] Master reset on ctrl-R ctrl-S Return, or reset with jumper set.
// [R17] Saved values keep being restored until a master reset erases them.
// [R18] Derivative gain defaults to 64 when nothing is saved.
// [R19] Acceleration replies use eight integer digits, no fraction.
package motion_cmd_pkg;
  localparam int AXES = 8;
  localparam int ACC_W = 27;
  localparam int GAIN_W = 16;
  // Register offsets (byte addresses)
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] AXIS_SEL_OFF = 8'h08;
  localparam logic [7:0] ACC_OFF = 8'h0C;
  localparam logic [7:0] GAIN_OFF = 8'h10;
  localparam logic [7:0] OOE_OFF = 8'h14;
  localparam logic [7:0] OPERAND_OFF = 8'h18;
  localparam logic [7:0] REPLY_OFF = 8'h1C;
  localparam logic [7:0] CHAR_OFF = 8'h20;
  localparam logic [7:0] MOVE_OFF = 8'h24;
  // Command codes written to CMD
  localparam logic [3:0] HALT_CODE = 4'h1;
  localparam logic [3:0] SERVO_CODE = 4'h2;
  localparam logic [3:0] SAVE_CODE = 4'h3;
  localparam logic [3:0] RESTART_CODE = 4'h4;
  localparam logic [3:0] FACTORY_CODE = 4'h5;
  // Quantum, limits and defaults
  localparam int ACC_LSB = 10;
  localparam logic [ACC_W-1:0] ACC_MIN = 27'd1024;
  localparam logic [ACC_W-1:0] ACC_MAX = 27'd67107840;
  localparam logic [ACC_W-1:0] ACC_DEF = 27'd25600;
  localparam logic [GAIN_W-1:0] GAIN_DEF = 16'h0040;
  localparam int ACC_INT_DIGITS = 8;
  localparam int DIGIT_CYC = ACC_INT_DIGITS;
  localparam logic [7:0] CH_CTRL_R = 8'h12;
  localparam logic [7:0] CH_CTRL_S = 8'h13;
  localparam logic [7:0] CH_RET = 8'h0D;
  localparam logic [7:0] CH_US = 8'h5F;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_X = 8'h58;
  // Per-axis setup parameter set
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [GAIN_W-1:0] gain;
  } axis_par_s;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_US,
    OP_A,
    OP_C
  } op_e;
endpackage

// ---- tb/axis_profiler_model.sv ----
// Behavioural motion profiler that stands behind the command block
`timescale 1ns/1ns
module axis_profiler_model
  (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] start_i,
  input wire logic [7:0] stop_i,
  output logic [7:0] moving_o
  );
  // ----------------------------------------
  // Axis motion state
  // ----------------------------------------
  // Started axes keep moving until stopped; a stop drops motion at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      moving_o <= 8'h00;
    end
    else
    begin
      moving_o <= (moving_o | start_i) & ~stop_i;
    end
  end
endmodule

// ---- tb/motion_abort_accel_params_tb_top.sv ----
// Self-checking bench of the motion command block
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module motion_abort_accel_params_tb_top;
  logic clk_i, rst_i, pwr, btn, jmp;
  logic [31:0] adr, dat, rdat, wb_dat_o;
  logic [3:0] sel;
  logic we, cyc, stb, wb_ack_o, program_stop_o, accel_update_o, pst, ce;
  logic [7:0] moving, motion_stop_o, amp_enable_o, mv_start, stp;
  int errors, compares, cycles, upd;
  logic [31:0] acc_in [7] = '{32'd1024, 32'd150000, 32'd200000, 32'd300000,
    32'd400000, 32'd67107840, 32'd2047};
  logic [26:0] acc_exp [7] = '{27'd1024, 27'd149504, 27'd199680, 27'd299008,
    27'd399360, 27'd67107840, 27'd1024};
  motion_cmd dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .power_on_i(pwr),
    .reset_button_i(btn), .factory_restore_jumper_i(jmp), .axis_moving_i(moving),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .motion_stop_o(motion_stop_o), .program_stop_o(program_stop_o),
    .amp_enable_o(amp_enable_o), .accel_update_o(accel_update_o));
  axis_profiler_model prof (.clk_i(clk_i), .rst_i(rst_i), .start_i(mv_start),
    .stop_i(motion_stop_o), .moving_o(moving));
  // ----------------------------------------
  // Clock, timeout and update counter
  // ----------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (accel_update_o === 1'b1) upd++;
    if (cycles > 5000)
    begin
      errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  // Classic single cycle; holds the request until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w,
    input logic [3:0] s);
    int n;
    n = 0;
    adr <= {24'h000000, a};
    dat <= d;
    we <= w;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      finish_test();
    end
    rdat = wb_dat_o;
    stp = motion_stop_o;
    pst = program_stop_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, d, 1'b1, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(a, 32'h00000000, 1'b0, 4'hF);
  endtask
  // Pulse one ordinary or master reset source for a single cycle
  task automatic pulse(input int which);
    if (which == 0) pwr <= 1'b1; else btn <= 1'b1;
    @(posedge clk_i);
    pwr <= 1'b0;
    btn <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst_i, pwr, btn, jmp, we, cyc, stb} = 7'b1000000;
    {adr, dat, sel, mv_start} = '0;
    ce = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(motion_cmd_pkg::ACC_OFF);
    `CHK("acc default", 32'd25600, rdat)
    rd(motion_cmd_pkg::GAIN_OFF);
    `CHK("gain default", 32'd64, rdat)
    mv_start <= 8'hFF;
    @(posedge clk_i);
    mv_start <= 8'h00;
    // Table: write, read back, interrogate and read operand while moving
    for (int i = 0; i < 7; i++)
    begin
      wr(motion_cmd_pkg::AXIS_SEL_OFF, i);
      wr(motion_cmd_pkg::ACC_OFF, acc_in[i]);
      rd(motion_cmd_pkg::ACC_OFF);
      `CHK("acc", {5'h00, acc_exp[i]}, rdat)
      wr(motion_cmd_pkg::REPLY_OFF, 32'h0);
      rd(motion_cmd_pkg::REPLY_OFF);
      `CHK("reply", {4'h8, 1'b0, acc_exp[i]}, rdat)
      wr(motion_cmd_pkg::OPERAND_OFF, 32'h5F);
      wr(motion_cmd_pkg::OPERAND_OFF, 32'h41);
      wr(motion_cmd_pkg::OPERAND_OFF, 32'h43);
      wr(motion_cmd_pkg::OPERAND_OFF, 32'h41 + i);
      rd(motion_cmd_pkg::OPERAND_OFF);
      `CHK("operand", {5'h00, acc_exp[i]}, rdat)
    end
    `CHK("accel updates", 7, upd)
    wr(motion_cmd_pkg::OPERAND_OFF, 32'h5F);
    wr(motion_cmd_pkg::OPERAND_OFF, 32'h4B);
    rd(motion_cmd_pkg::OPERAND_OFF);
    `CHK("bad operand", 32'h0, rdat)
    // Halt with program stop, off-on-error on axes 0 and 2
    wr(motion_cmd_pkg::OOE_OFF, 32'h05);
    wr(motion_cmd_pkg::CMD_OFF, 32'h01);
    `CHK("stop all", 8'hFF, stp)
    `CHK("prog stop", 1'b1, pst)
    rd(motion_cmd_pkg::STATUS_OFF);
    `CHK("amp off", 8'hFA, rdat[7:0])
    `CHK("halt prog flag", 1'b1, rdat[10])
    `CHK("moving", 8'h00, moving)
    wr(motion_cmd_pkg::CMD_OFF, 32'h02);
    `CHK("amp on", 8'hFF, amp_enable_o)
    mv_start <= 8'h30;
    @(posedge clk_i);
    mv_start <= 8'h00;
    wr(motion_cmd_pkg::CMD_OFF, 32'h11);
    `CHK("stop moving", 8'h30, stp)
    `CHK("prog runs", 1'b0, pst)
    // Persistence across ordinary resets, then master resets
    for (int m = 0; m < 3; m++)
    begin
      wr(motion_cmd_pkg::AXIS_SEL_OFF, 32'h0);
      wr(motion_cmd_pkg::GAIN_OFF, 32'h77);
      wr(motion_cmd_pkg::CMD_OFF, 32'h03);
      wr(motion_cmd_pkg::GAIN_OFF, 32'h11);
      wb(motion_cmd_pkg::GAIN_OFF, 32'h22, 1'b1, 4'hE);
      // A reset request while the clock enable is low must change nothing
      ce <= 1'b0;
      pulse(0);
      ce <= 1'b1;
      rd(motion_cmd_pkg::GAIN_OFF);
      `CHK("frozen unsaved gain", 32'h11, rdat)
      wr(motion_cmd_pkg::CMD_OFF, 32'h04);
      rd(motion_cmd_pkg::GAIN_OFF);
      `CHK("restored", 32'h77, rdat)
      pulse(1);
      pulse(0);
      rd(motion_cmd_pkg::GAIN_OFF);
      `CHK("kept saved", 32'h77, rdat)
      rd(motion_cmd_pkg::STATUS_OFF);
      `CHK("saved flag", 1'b1, rdat[9])
      if (m == 0)
      begin
        wr(motion_cmd_pkg::CHAR_OFF, 32'h12);
        wr(motion_cmd_pkg::CHAR_OFF, 32'h13);
        wr(motion_cmd_pkg::CHAR_OFF, 32'h0D);
      end
      else if (m == 1)
      begin
        jmp <= 1'b1;
        pulse(1);
        jmp <= 1'b0;
      end
      else
        wr(motion_cmd_pkg::CMD_OFF, 32'h05);
      pulse(1);
      rd(motion_cmd_pkg::GAIN_OFF);
      `CHK("factory gain", 32'd64, rdat)
      rd(motion_cmd_pkg::STATUS_OFF);
      `CHK("image erased", 1'b0, rdat[9])
    end
    rd(8'h30);
    `CHK("unmapped", 32'h0, rdat)
    finish_test();
  end
endmodule
